// ### core/rbs_pkg.sv
package rbs_pkg;
   localparam int unsigned WD_PULSE_CYC  = 512;
   localparam int unsigned BUS_DELAY_CYC = 32;
   localparam int unsigned ROM_DELAY_SYS = 1260;
   localparam int unsigned BOOT_W        = 4;
   localparam logic [3:0]  BOOT_JUMP_CODE = 4'hf;
   localparam int unsigned AW            = 2;
   localparam int unsigned DW            = 8;

   localparam logic [1:0]  OFS_IFCFG2    = 2'h0;
   localparam logic [1:0]  OFS_PLLCTL    = 2'h1;
   localparam logic [1:0]  OFS_STATUS    = 2'h2;
   localparam logic [1:0]  OFS_BOOTCTL   = 2'h3;

   localparam int unsigned FLD_XTIM      = 0;
   localparam int unsigned FLD_OUTDIV    = 1;
   localparam int unsigned FLD_SYSFAST   = 0;
   localparam int unsigned FLD_RERUN     = 0;

   localparam logic        RST_XTIM      = 1'b1;
   localparam logic        RST_OUTDIV    = 1'b1;
   localparam logic        RST_SYSFAST   = 1'b0;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b001,
      ST_ROM  = 3'b010,
      ST_RUN  = 3'b100
   } rbs_state_t;
endpackage : rbs_pkg

// ### core/rbs_sync.sv
`timescale 1ns/100ps
module rbs_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] q_d;
   wire  [W-1:0] agree = ~(s2_q ^ s3_q);

   // A bit only moves once the second and third stages agree
   assign q_d = (s2_q & agree) | (q & ~agree);

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         q    <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q    <= q_d;
      end
   end
endmodule : rbs_sync

// ### core/rbs_div.sv
`timescale 1ns/100ps
module rbs_div #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         clr,
   input  wire logic         tick_in,
   input  wire logic [W-1:0] half_len,
   output logic              level_q,
   output logic              rise
);
   logic [W-1:0] cnt_q;
   wire  [W:0]   nxt  = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};
   // A half length of zero behaves as one
   wire          last = tick_in && (nxt >= {1'b0, half_len});

   assign rise = last && !level_q;

   always_ff @(posedge clk) begin
      if (rst || clr) begin
         cnt_q   <= '0;
         level_q <= 1'b0;
      end else if (last) begin
         cnt_q   <= '0;
         level_q <= !level_q;
      end else if (tick_in) begin
         cnt_q   <= nxt[W-1:0];
      end
   end
endmodule : rbs_div

// ### core/rbs_reset_boot.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module rbs_reset_boot #(
   parameter int                BOOT_W    = rbs_pkg::BOOT_W,
   parameter logic [BOOT_W-1:0] JUMP_CODE = rbs_pkg::BOOT_JUMP_CODE
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   device_reset_n,
   input  wire logic                   watchdog_reset_req,
   input  wire logic                   pll_bypass_pin,
   input  wire logic                   boot_source_select_pin,
   input  wire logic [BOOT_W-1:0]      boot_mode_pins,
   input  wire logic [rbs_pkg::AW-1:0] reg_addr,
   input  wire logic [rbs_pkg::DW-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [rbs_pkg::DW-1:0] reg_rdata,
   output logic                        internal_reset,
   output logic                        ext_bus_valid,
   output logic                        system_clock,
   output logic                        system_clock_tick,
   output logic                        external_clock_out,
   output logic                        boot_ext_mode,
   output logic                        boot_done,
   output logic                        boot_to_memory,
   output logic                        boot_to_loader,
   output logic      [BOOT_W-1:0]      boot_mode_latched
);
   localparam int SW = BOOT_W + 2;

   logic                 rstn_s;
   logic [SW-1:0]        strap_s;
   logic [9:0]           wd_cnt_q;
   logic [9:0]           wd_cnt_d;
   logic                 core_reset_q;
   logic [5:0]           bus_cnt_q;
   logic                 bus_valid_q;
   rbs_pkg::rbs_state_t  st_q;
   rbs_pkg::rbs_state_t  st_d;
   logic [10:0]          rom_cnt_q;
   logic                 boot_ext_q;
   logic                 byp_q;
   logic [BOOT_W-1:0]    mode_q;
   logic                 to_mem_q;
   logic                 to_ldr_q;
   logic                 xtim_q;
   logic                 outdiv_q;
   logic                 sysfast_q;
   logic [rbs_pkg::DW-1:0] rdata_q;
   logic                 sys_level;
   logic                 sys_rise;
   logic                 xclk_level;

   // Pins cross into the input clock domain
   rbs_sync #(.W(1), .INIT(1'b0)) u_rst_sync (
      .clk (clk),
      .rst (rst),
      .d   (device_reset_n),
      .q   (rstn_s)
   );

   rbs_sync #(.W(SW), .INIT('0)) u_strap_sync (
      .clk (clk),
      .rst (rst),
      .d   ({pll_bypass_pin, boot_source_select_pin, boot_mode_pins}),
      .q   (strap_s)
   );

   // Watchdog pulse: loads once, retriggers are ignored while it runs
   wire wd_active = (wd_cnt_q != 10'h000);
   assign wd_cnt_d = wd_active ? wd_cnt_q - 10'h001
                   : (watchdog_reset_req ? 10'(rbs_pkg::WD_PULSE_CYC) : 10'h000);

   always_ff @(posedge clk) begin
      if (rst) begin
         wd_cnt_q     <= 10'h000;
         core_reset_q <= 1'b1;
      end else begin
         wd_cnt_q     <= wd_cnt_d;
         core_reset_q <= !rstn_s || wd_active;
      end
   end

   // External interface goes valid a fixed delay after release
   wire bus_hit = (bus_cnt_q == 6'(rbs_pkg::BUS_DELAY_CYC - 1));

   always_ff @(posedge clk) begin
      if (rst || core_reset_q) begin
         bus_cnt_q   <= 6'h00;
         bus_valid_q <= 1'b0;
      end else if (!bus_valid_q) begin
         bus_cnt_q   <= bus_cnt_q + 6'h01;
         bus_valid_q <= bus_hit;
      end
   end

   // Register decode
   wire wr_ok    = reg_wr && !core_reset_q;
   wire wr_ifcfg = wr_ok && (reg_addr == rbs_pkg::OFS_IFCFG2);
   wire wr_pllctl = wr_ok && (reg_addr == rbs_pkg::OFS_PLLCTL);
   wire wr_boot  = wr_ok && (reg_addr == rbs_pkg::OFS_BOOTCTL);
   // External start never runs the strap sampling, not even on a rerun
   wire rerun    = wr_boot && reg_wdata[rbs_pkg::FLD_RERUN] && (st_q == rbs_pkg::ST_RUN) && !boot_ext_q;

   always_ff @(posedge clk) begin
      if (rst || core_reset_q) begin
         xtim_q    <= rbs_pkg::RST_XTIM;
         outdiv_q  <= rbs_pkg::RST_OUTDIV;
         sysfast_q <= rbs_pkg::RST_SYSFAST;
      end else begin
         if (wr_ifcfg) begin
            xtim_q    <= reg_wdata[rbs_pkg::FLD_XTIM];
            outdiv_q  <= reg_wdata[rbs_pkg::FLD_OUTDIV];
         end
         if (wr_pllctl) begin
            sysfast_q <= reg_wdata[rbs_pkg::FLD_SYSFAST];
         end
      end
   end

   // Clock tree: full rate is refused while the PLL bypass strap latched at release is set
   wire sys_fast = sysfast_q && !byp_q;

   rbs_div #(.W(1)) u_sys_div (
      .clk      (clk),
      .rst      (rst),
      .clr      (1'b0),
      .tick_in  (1'b1),
      .half_len (1'b1),
      .level_q  (sys_level),
      .rise     (sys_rise)
   );

   wire sys_tick = sys_fast || sys_rise;
   wire [1:0] xhalf = {1'b0, xtim_q} + {1'b0, outdiv_q};

   rbs_div #(.W(2)) u_xclk_div (
      .clk      (clk),
      .rst      (rst),
      .clr      (core_reset_q),
      .tick_in  (sys_tick),
      .half_len (xhalf),
      .level_q  (xclk_level),
      .rise     ()
   );

   // Boot sequencer
   wire rom_last = sys_tick && (rom_cnt_q == 11'(rbs_pkg::ROM_DELAY_SYS - 1));
   wire sample_p = (st_q == rbs_pkg::ST_ROM) && rom_last;
   wire jump_hit = (strap_s[BOOT_W-1:0] == JUMP_CODE);

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         rbs_pkg::ST_HOLD: begin
            if (!core_reset_q) begin
               st_d = strap_s[BOOT_W] ? rbs_pkg::ST_RUN : rbs_pkg::ST_ROM;
            end
         end
         rbs_pkg::ST_ROM: begin
            if (rom_last) begin
               st_d = rbs_pkg::ST_RUN;
            end
         end
         rbs_pkg::ST_RUN: begin
            if (rerun) begin
               st_d = rbs_pkg::ST_ROM;
            end
         end
         default: st_d = rbs_pkg::ST_HOLD;
      endcase
      if (core_reset_q) begin
         st_d = rbs_pkg::ST_HOLD;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= rbs_pkg::ST_HOLD;
      end else begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || core_reset_q || rerun) begin
         rom_cnt_q <= 11'h000;
      end else if ((st_q == rbs_pkg::ST_ROM) && sys_tick) begin
         rom_cnt_q <= rom_cnt_q + 11'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || core_reset_q) begin
         mode_q   <= '0;
         to_mem_q <= 1'b0;
         to_ldr_q <= 1'b0;
      end else if (rerun) begin
         to_mem_q <= 1'b0;
         to_ldr_q <= 1'b0;
      end else if (sample_p) begin
         mode_q   <= strap_s[BOOT_W-1:0];
         to_mem_q <= jump_hit;
         to_ldr_q <= !jump_hit;
      end
   end

   // Source and bypass straps are taken in the first cycle out of reset
   always_ff @(posedge clk) begin
      if (rst) begin
         boot_ext_q <= 1'b0;
         byp_q      <= 1'b0;
      end else if ((st_q == rbs_pkg::ST_HOLD) && !core_reset_q) begin
         boot_ext_q <= strap_s[BOOT_W];
         byp_q      <= strap_s[BOOT_W+1];
      end
   end

   // Read path
   wire [rbs_pkg::DW-1:0] rd_ifcfg  = rbs_pkg::DW'({outdiv_q, xtim_q});
   wire [rbs_pkg::DW-1:0] rd_pllctl = rbs_pkg::DW'(sysfast_q);
   wire [rbs_pkg::DW-1:0] rd_status = rbs_pkg::DW'({st_q, bus_valid_q, byp_q, boot_ext_q});
   wire [rbs_pkg::DW-1:0] rd_boot   = rbs_pkg::DW'({to_ldr_q, to_mem_q, mode_q});
   wire [rbs_pkg::DW-1:0] rd_mux    = (reg_addr == rbs_pkg::OFS_IFCFG2) ? rd_ifcfg
                                    : (reg_addr == rbs_pkg::OFS_PLLCTL) ? rd_pllctl
                                    : (reg_addr == rbs_pkg::OFS_STATUS) ? rd_status
                                    : rd_boot;

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= reg_rd ? rd_mux : '0;
      end
   end

   assign reg_rdata          = rdata_q;
   assign internal_reset     = core_reset_q;
   assign ext_bus_valid      = bus_valid_q;
   assign system_clock       = sys_level;
   assign system_clock_tick  = sys_tick;
   assign external_clock_out = xclk_level;
   assign boot_ext_mode      = boot_ext_q;
   assign boot_done          = (st_q == rbs_pkg::ST_RUN);
   assign boot_to_memory     = to_mem_q;
   assign boot_to_loader     = to_ldr_q;
   assign boot_mode_latched  = mode_q;

   // Checking helpers
   logic [9:0]  hlp_wd_q;
   logic [11:0] hlp_rel_q;
   logic [11:0] hlp_sys_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         hlp_wd_q  <= 10'h000;
         hlp_rel_q <= 12'h000;
         hlp_sys_q <= 12'h000;
      end else begin
         hlp_wd_q  <= wd_active ? hlp_wd_q + 10'h001 : 10'h000;
         hlp_rel_q <= core_reset_q ? 12'h000 : (hlp_rel_q == 12'hfff ? hlp_rel_q : hlp_rel_q + 12'h001);
         hlp_sys_q <= (st_q != rbs_pkg::ST_ROM) ? 12'h000 : hlp_sys_q + {11'h000, sys_tick};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_xclk_rise;
      $rose(external_clock_out) && xtim_q && outdiv_q && !sys_fast;
   endsequence

   sequence s_xclk_period;
      ##4 $fell(external_clock_out) ##4 $rose(external_clock_out);
   endsequence

   a_wdog_pulse_len: assert property ($fell(wd_active) |-> hlp_wd_q == 10'(rbs_pkg::WD_PULSE_CYC))
      else $error("watchdog reset pulse length wrong");

   a_bus_valid_delay: assert property (ext_bus_valid == (hlp_rel_q >= 12'(rbs_pkg::BUS_DELAY_CYC)))
      else $error("external interface valid at wrong time");

   a_sysclk_half: assert property (!sys_fast && $rose(system_clock) |-> ##1 $fell(system_clock) ##1 $rose(system_clock))
      else $error("system clock not half of input clock");

   // A register write may legally change the rate inside a period
   a_xclk_eighth: assert property (disable iff (rst || internal_reset || reg_wr) s_xclk_rise |-> s_xclk_period)
      else $error("external clock not input over eight");

   a_rom_delay_len: assert property (sample_p |-> sys_tick && hlp_sys_q == 12'(rbs_pkg::ROM_DELAY_SYS - 1))
      else $error("straps sampled after wrong delay");

   a_branch_pick: assert property (sample_p && !core_reset_q |=> boot_to_memory == $past(jump_hit) && boot_to_loader == !$past(jump_hit))
      else $error("boot branch does not follow straps");

   a_rom_live_clk: assert property ((st_q == rbs_pkg::ST_ROM) && !sys_tick && !core_reset_q |=> $stable(rom_cnt_q))
      else $error("boot delay counted without a system clock");

   a_strap_latch: assert property ($fell(internal_reset) |=> boot_ext_mode == $past(strap_s[BOOT_W]) && boot_done == boot_ext_mode)
      else $error("boot source not latched at release");

   a_ext_no_sample: assert property (boot_ext_mode && boot_done |-> !boot_to_memory && !boot_to_loader)
      else $error("external start ran strap sampling");

   a_warm_rerun: assert property (internal_reset |=> !boot_done && xtim_q && outdiv_q && !ext_bus_valid)
      else $error("reset did not restore release sequence");
endmodule : rbs_reset_boot

// ### verification/rbs_board.sv
`timescale 1ns/100ps
// Board side: reset supervisor and strap drivers
module rbs_board (
   input  wire logic       clk,
   output logic            device_reset_n,
   output logic            pll_bypass_pin,
   output logic            boot_source_select_pin,
   output logic [3:0]      boot_mode_pins
);
   int since_q = 0;

   initial begin
      device_reset_n = 1'b0;
      pll_bypass_pin = 1'b0;
      boot_source_select_pin = 1'b0;
      boot_mode_pins = 4'h0;
   end

   // Straps are let go once their hold time has run out
   always @(posedge clk) begin
      since_q <= device_reset_n ? since_q + 1 : 0;
      if (since_q == 16) begin
         boot_source_select_pin <= 1'b0;
         pll_bypass_pin <= ~pll_bypass_pin;
      end
      if (since_q == 2600) begin
         boot_mode_pins <= ~boot_mode_pins;
      end
   end

   task automatic apply(input logic src, input logic byp, input logic [3:0] mode, input int low);
      @(posedge clk);
      pll_bypass_pin <= byp;
      boot_source_select_pin <= src;
      boot_mode_pins <= mode;
      repeat (16) @(posedge clk);
      device_reset_n <= 1'b0;
      repeat (low) @(posedge clk);
      device_reset_n <= 1'b1;
   endtask : apply
endmodule : rbs_board

// ### verification/test_reset_release_boot_sequencer.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; $display("Error %s exp %0h got %0h", nm, ex, gt); end end
module test_reset_release_boot_sequencer;
   typedef struct {logic src; logic byp; logic [3:0] mode; logic mem; logic ldr;} rbs_row_t;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       watchdog_reset_req = 1'b0;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       device_reset_n, pll_bypass_pin, boot_source_select_pin;
   logic [3:0] boot_mode_pins, boot_mode_latched;
   logic       internal_reset, ext_bus_valid, system_clock, system_clock_tick;
   logic       external_clock_out, boot_ext_mode, boot_done, boot_to_memory, boot_to_loader;
   int         n_fail = 0;
   int         cmp_count = 0;
   int         n, cyc, e;
   time        t0, t_done;
   rbs_row_t   rows [4] = '{'{1'b1, 1'b0, 4'h3, 1'b0, 1'b0}, '{1'b0, 1'b0, 4'hf, 1'b1, 1'b0},
                            '{1'b0, 1'b0, 4'h5, 1'b0, 1'b1}, '{1'b0, 1'b1, 4'h0, 1'b0, 1'b1}};

   rbs_reset_boot rbs_reset_boot_i (.clk(clk), .rst(rst), .device_reset_n(device_reset_n),
      .watchdog_reset_req(watchdog_reset_req), .pll_bypass_pin(pll_bypass_pin),
      .boot_source_select_pin(boot_source_select_pin), .boot_mode_pins(boot_mode_pins),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .internal_reset(internal_reset), .ext_bus_valid(ext_bus_valid), .system_clock(system_clock),
      .system_clock_tick(system_clock_tick), .external_clock_out(external_clock_out),
      .boot_ext_mode(boot_ext_mode), .boot_done(boot_done), .boot_to_memory(boot_to_memory),
      .boot_to_loader(boot_to_loader), .boot_mode_latched(boot_mode_latched));

   rbs_board rbs_board_i (.clk(clk), .device_reset_n(device_reset_n), .pll_bypass_pin(pll_bypass_pin),
      .boot_source_select_pin(boot_source_select_pin), .boot_mode_pins(boot_mode_pins));

   // Time of the latest entry into the run state
   always @(posedge boot_done) t_done = $time;

   initial begin
      forever #25 clk = ~clk;
   end

   function automatic logic sig(input int k);
      case (k)
         0: return internal_reset;
         1: return boot_done;
         2: return system_clock;
         3: return external_clock_out;
         default: return ext_bus_valid;
      endcase
   endfunction : sig

   // Counts edges until the chosen output reaches v, bounded
   task automatic wt(input int k, input logic v, output int cnt);
      cnt = 0;
      while (sig(k) !== v && cnt < 4000) begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : wt

   task automatic period(input int k, output int cnt);
      int x;
      wt(k, 1'b0, x);
      wt(k, 1'b1, x);
      wt(k, 1'b0, x);
      wt(k, 1'b1, cnt);
      cnt = cnt + x;
   endtask : period

   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] ad, input logic [7:0] ex);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rdata", ex, reg_rdata)
      @(posedge clk);
      #1;
      `CHK("reg_rdata_idle", 8'h00, reg_rdata)
   endtask : rd

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         rbs_board_i.apply(rows[i].src, rows[i].byp, rows[i].mode, 8);
         wt(0, 1'b0, n);
         t0 = $time;
         wt(4, 1'b1, n);
         `CHK("bus_delay", 32, n)
         `CHK("boot_ext_mode", rows[i].src, boot_ext_mode)
         period(3, n);
         `CHK("xclk_period", 8, n)
         period(2, n);
         `CHK("sysclk_period", 2, n)
         wt(1, 1'b1, n);
         cyc = int'((t_done - t0 + 1) / 50);
         e = rows[i].src ? 1 : 2521;
         `CHK("boot_delay", 1'b1, cyc >= e - 2 && cyc <= e + 2)
         `CHK("to_memory", rows[i].mem, boot_to_memory)
         `CHK("to_loader", rows[i].ldr, boot_to_loader)
         if (!rows[i].src) `CHK("mode_latched", rows[i].mode, boot_mode_latched)
      end
      // Watchdog pulse with a second request inside it
      @(posedge clk);
      watchdog_reset_req <= 1'b1;
      @(posedge clk);
      watchdog_reset_req <= 1'b0;
      wt(0, 1'b1, n);
      @(posedge clk);
      watchdog_reset_req <= 1'b1;
      @(posedge clk);
      watchdog_reset_req <= 1'b0;
      wt(0, 1'b0, n);
      `CHK("wd_pulse", 512, n + 2)
      wt(4, 1'b1, n);
      `CHK("wd_bus_delay", 32, n)
      wt(1, 1'b1, n);
      `CHK("wd_boot_done", 1'b1, boot_done)
      // Full-rate system clock then boot rerun
      wr(2'h1, 8'h01);
      repeat (3) begin
         @(posedge clk);
         #1;
         `CHK("tick", 1'b1, system_clock_tick)
      end
      wr(2'h3, 8'h01);
      t0 = $time;
      wt(1, 1'b0, n);
      wt(1, 1'b1, n);
      cyc = int'(($time - t0) / 50);
      `CHK("rerun_delay", 1'b1, cyc >= 1259 && cyc <= 1265)
      rd(2'h2, 8'h24);
      rd(2'h0, 8'h03);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h00);
      period(3, n);
      `CHK("xclk_fast", 2, n)
      // Warm reset restores the power-on divider defaults, bypass strap set
      rbs_board_i.apply(1'b0, 1'b1, 4'h5, 8);
      wt(0, 1'b0, n);
      rd(2'h0, 8'h03);
      rd(2'h1, 8'h00);
      period(3, n);
      `CHK("xclk_warm", 8, n)
      // Full rate is refused while the bypass strap is latched
      wr(2'h1, 8'h01);
      period(3, n);
      `CHK("xclk_bypass", 8, n)
      close_out();
   end
endmodule : test_reset_release_boot_sequencer
